// >>> i2c_start_pkg.sv
/*
  Constants shared by the START generator and its baud countdown.
  Assumes nothing beyond a SystemVerilog tool that reads packages.
*/
package i2c_start_pkg;
  // Reload field width and countdown target
  localparam int RELOAD_WIDTH = 7;
  localparam logic [6:0] COUNT_END = 7'h00;
  // Reset values
  localparam logic [6:0] RELOAD_RESET = 7'h00;
  // Edges the check phase waits so released lines pass both synchroniser stages
  localparam logic [1:0] SETTLE_CYCLES = 2'h2;
  // Sequencer states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_CHECK,
    ST_FIRST,
    ST_SECOND,
    ST_DONE
  } start_state_t;
endpackage

// >>> baud_countdown.sv
/*
  Reloadable down counter that times each phase of a START condition.
  Assumes load and clear come from logic on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module baud_countdown
  import i2c_start_pkg::*;
#(
  parameter int WIDTH = RELOAD_WIDTH
)
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Control
  input wire logic load,
  input wire logic clear,
  input wire logic [WIDTH-1:0] reload_value,
  // Status
  output logic expired
);
  logic [WIDTH-1:0] count;
  logic running;

  initial
  begin
    if (WIDTH < 1)
    begin
      $error("baud_countdown: WIDTH must be at least 1");
    end
  end

  // Count down from the reload value; clear wins so an early SDA low cancels the phase
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      count <= '0;
      running <= 1'b0;
    end
    else if (clear)
    begin
      count <= '0;
      running <= 1'b0;
    end
    else if (load)
    begin
      count <= reload_value;
      running <= 1'b1;
    end
    else if (running && count != '0)
    begin
      count <= count - 1'b1;
    end
    else
    begin
      running <= 1'b0;
    end
  end

  // One-cycle pulse when a running count reaches zero
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      expired <= 1'b0;
    end
    else
    begin
      expired <= running && !load && !clear && count == '0;
    end
  end
endmodule // baud_countdown
`default_nettype wire

// >>> i2c_master_start_collision.sv
/*
  I2C master START generator with collision detection on open-drain SDA and SCL.
  Lines stay low after a finished START until the next request releases them.
  Assumes pin inputs are asynchronous and the partner keeps its own I2C rules.
*/
`timescale 1ns/1ps
`default_nettype none
module i2c_master_start_collision
  import i2c_start_pkg::*;
#(
  parameter int RELOAD_W = RELOAD_WIDTH
)
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Control from the serial module
  input wire logic start_request,
  input wire logic [RELOAD_W-1:0] baud_reload_value,
  input wire logic collision_clear,
  // Status to the serial module
  output logic start_busy,
  output logic start_done,
  output logic bus_collision_flag,
  // Open-drain SDA
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // Open-drain SCL
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe
);
  // Sequencer
  start_state_t state;
  start_state_t next_state;
  logic [1:0] settle;
  logic settle_done;

  // Synchronised pins
  logic sda_meta;
  logic sda_sync;
  logic scl_meta;
  logic scl_sync;

  // Countdown control
  logic count_load;
  logic count_clear;
  logic count_load_any;
  logic count_expired;

  // Line drive and collision
  logic collision_event;
  logic next_sda_drive;
  logic next_scl_drive;

  initial
  begin
    if (RELOAD_W != RELOAD_WIDTH)
    begin
      $error("i2c_master_start_collision: reload width must be seven");
    end
    if (SETTLE_CYCLES < 2'h2)
    begin
      $error("i2c_master_start_collision: settle count must cover both synchroniser stages");
    end
  end

  // Two-stage synchronisers; only the second stage feeds logic
  // They reset to the released high level, so no false low line follows reset
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sda_meta <= 1'b1;
      sda_sync <= 1'b1;
      scl_meta <= 1'b1;
      scl_sync <= 1'b1;
    end
    else
    begin
      sda_meta <= sda_in;
      sda_sync <= sda_meta;
      scl_meta <= scl_in;
      scl_sync <= scl_meta;
    end
  end

  // Phase timer
  // One generator serves both phases; the clear of the first lands before the second load
  baud_countdown #(
    .WIDTH(RELOAD_W)
  ) u_baud_rate_generator (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .load(count_load_any),
    .clear(count_clear),
    .reload_value(baud_reload_value),
    .expired(count_expired)
  );

  // Settle count for the check phase: releasing the lines at the request takes two more
  // edges to reach the synchronisers, and a line we held low must not look like a rival
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      settle <= 2'h0;
    end
    else if (state != ST_CHECK)
    begin
      settle <= 2'h0;
    end
    else if (settle != SETTLE_CYCLES)
    begin
      settle <= settle + 2'h1;
    end
  end

  // The check phase decides only once the lines are seen as they stand now
  assign settle_done = settle == SETTLE_CYCLES;

  // Sequencer; the second phase ignores SCL since another master may already be clocking
  always_comb
  begin
    next_state = state;
    count_load = 1'b0;
    count_clear = 1'b0;
    collision_event = 1'b0;
    unique case (state)
      ST_IDLE:
      begin
        if (start_request)
        begin
          next_state = ST_CHECK;
        end
      end
      ST_CHECK:
      begin
        if (!settle_done)
        begin
          next_state = ST_CHECK; // Released lines have not reached the synchronisers yet
        end
        else if (!sda_sync || !scl_sync)
        begin
          collision_event = 1'b1;
          next_state = ST_IDLE;
        end
        else
        begin
          count_load = 1'b1;
          next_state = ST_FIRST;
        end
      end
      ST_FIRST:
      begin
        if (!scl_sync)
        begin
          collision_event = 1'b1;
          count_clear = 1'b1;
          next_state = ST_IDLE;
        end
        else if (!sda_sync || count_expired)
        begin
          // Early SDA low from another master is a START in progress, not a collision
          count_clear = 1'b1;
          next_state = ST_SECOND;
        end
      end
      ST_SECOND:
      begin
        // SCL pulled low now is a rival's clock, not a collision
        if (count_expired)
        begin
          next_state = ST_DONE;
        end
      end
      ST_DONE:
      begin
        next_state = ST_IDLE;
      end
      default:
      begin
        next_state = ST_IDLE; // Unused state codes fall back to idle
      end
    endcase
  end

  // Second phase reload lands one cycle after the first phase ends
  // Registered so the clear of the first phase and the reload never meet in one cycle
  logic reload_second;
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state <= ST_IDLE;
      reload_second <= 1'b0;
    end
    else
    begin
      state <= next_state;
      reload_second <= state == ST_FIRST && next_state == ST_SECOND;
    end
  end

  // Second countdown; SCL is not checked here
  logic second_load;
  assign second_load = reload_second;
  // Either phase loads the generator
  assign count_load_any = count_load | second_load;

  // Line drive levels
  always_comb
  begin
    next_sda_drive = sda_oe;
    next_scl_drive = scl_oe;
    // Only an abort or a new request releases both lines; after a finished START they stay low,
    // since letting SDA rise while SCL is high would put a STOP on the bus
    if (collision_event)
    begin
      next_sda_drive = 1'b0;
      next_scl_drive = 1'b0;
    end
    if (state == ST_IDLE && next_state == ST_CHECK)
    begin
      next_sda_drive = 1'b0;
      next_scl_drive = 1'b0;
    end
    if (state == ST_FIRST && next_state == ST_SECOND)
    begin
      next_sda_drive = 1'b1;
    end
    if (state == ST_SECOND && next_state == ST_DONE)
    begin
      next_scl_drive = 1'b1;
    end
  end

  // Open-drain drivers: output value is always low, the enable does the work
  // Lines that stay driven after START wait for the next request to release them
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sda_oe <= 1'b0;
      scl_oe <= 1'b0;
      sda_out <= 1'b0;
      scl_out <= 1'b0;
    end
    else
    begin
      sda_oe <= next_sda_drive;
      scl_oe <= next_scl_drive;
      sda_out <= 1'b0;
      scl_out <= 1'b0;
    end
  end

  // Status pulses and busy level
  // Busy follows the next state so it rises on the same edge as the release
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      start_busy <= 1'b0;
      start_done <= 1'b0;
    end
    else
    begin
      start_busy <= next_state != ST_IDLE;
      start_done <= next_state == ST_DONE;
    end
  end

  // Sticky collision flag; a new collision wins over a clear in the same cycle
  // A clear only touches the flag, never the line drivers
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      bus_collision_flag <= 1'b0;
    end
    else if (collision_event)
    begin
      bus_collision_flag <= 1'b1;
    end
    else if (collision_clear)
    begin
      bus_collision_flag <= 1'b0;
    end
  end
endmodule // i2c_master_start_collision
`default_nettype wire

// >>> i2c_start_asserts.sv
/*
  Port checker for the START generator with collision detection.
  Assumes it is bound to i2c_master_start_collision on one clock.
*/
`timescale 1ns/1ps
`default_nettype none
module i2c_start_asserts
  import i2c_start_pkg::*;
#(
  parameter int RELOAD_W = RELOAD_WIDTH
)
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Control and status
  input wire logic start_request,
  input wire logic [RELOAD_W-1:0] baud_reload_value,
  input wire logic collision_clear,
  input wire logic start_busy,
  input wire logic start_done,
  input wire logic bus_collision_flag,
  // Lines
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic scl_in,
  input wire logic scl_out,
  input wire logic scl_oe
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  logic [8:0] held;
  // Cycles with SDA driven; a countdown that never reloads shows up short
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      held <= 9'h000;
    else
      held <= sda_oe ? held + 9'h001 : 9'h000;
  end
  sequence s_first_hi; (start_busy && !sda_oe && sda_in) [*3]; endsequence
  sequence s_first_lo; (start_busy && !sda_oe && !sda_in) [*3]; endsequence
  property p_outs; !sda_out && !scl_out; endproperty
  property p_begin; $rose(start_busy) |-> ##[0:2] (!sda_oe && !scl_oe); endproperty
  property p_abort; $rose(bus_collision_flag) |-> ##[0:3] (!start_busy && !sda_oe && !scl_oe); endproperty
  property p_scl_coll; (start_busy && !sda_oe && sda_in && !scl_in) [*3] |-> ##[0:4] bus_collision_flag; endproperty
  property p_early; s_first_hi ##1 s_first_lo |-> ##[0:4] sda_oe; endproperty
  property p_order; $rose(scl_oe) |-> sda_oe; endproperty
  property p_second; start_done |-> held >= 9'(baud_reload_value); endproperty
  property p_done; start_done |-> (scl_oe && sda_oe) ##1 !start_done; endproperty
  property p_sticky; bus_collision_flag && !collision_clear |=> bus_collision_flag; endproperty
  property p_clear; collision_clear && !start_busy && !start_request |=> !bus_collision_flag && $stable(sda_oe); endproperty
  a_outs: assert property (p_outs) else $error("line driven high");
  a_begin: assert property (p_begin) else $error("start not released");
  a_abort: assert property (p_abort) else $error("abort missing");
  a_scl_coll: assert property (p_scl_coll) else $error("scl collision missed");
  a_early: assert property (p_early) else $error("sda not early");
  a_order: assert property (p_order) else $error("scl before sda");
  a_second: assert property (p_second) else $error("second count short");
  a_done: assert property (p_done) else $error("done wrong");
  a_sticky: assert property (p_sticky) else $error("flag lost");
  a_clear: assert property (p_clear) else $error("clear failed");
endmodule // i2c_start_asserts
bind i2c_master_start_collision i2c_start_asserts #(.RELOAD_W(RELOAD_W)) u_asserts (.*);
`default_nettype wire

// >>> i2c_far_end.sv
/*
  Far-end model: another master or slave that pulls SDA or SCL low.
  Assumes the bench picks a mode and pulses go before each START.
*/
`timescale 1ns/1ps
`default_nettype none
module i2c_far_end
(
  // Clock and control
  input wire logic clk_sys,
  input wire logic go,
  input wire logic [2:0] mode,
  // Device SDA drive seen on the wire
  input wire logic sda_oe,
  // Pulls, high means line held low
  output logic sda_pull,
  output logic scl_pull
);
  logic [4:0] cnt;
  // Cycles since go, saturating so a late pull holds
  always_ff @(posedge clk_sys)
    cnt <= go ? 5'h00 : cnt + ((cnt != 5'h1F) ? 5'h01 : 5'h00);
  // Pull-only outputs; mode 3 is a rival master starting a little later
  always_comb
  begin
    sda_pull = (mode == 3'h1) || (mode == 3'h3 && cnt > 5'h06);
    scl_pull = (mode == 3'h2 && cnt > 5'h06) || (mode == 3'h4 && sda_oe);
  end
endmodule // i2c_far_end
`default_nettype wire

// >>> tb_top.sv
/*
  Self-checking bench for the START generator.
  Assumes the far-end model and the bound checker are compiled alongside.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin err_count++; \
  $display("ERROR t=%0t got %h exp %h", $time, a, b); end end
module tb_top;
  logic clk_sys, reset_n, start_request, collision_clear, go;
  logic [6:0] reload;
  logic [2:0] mode;
  logic start_busy, start_done, bus_collision_flag, sda_out, sda_oe, scl_out, scl_oe;
  logic sda_pull, scl_pull;
  int err_count, tests_run;
  logic [2:0] modes [6] = '{3'h0, 3'h1, 3'h3, 3'h2, 3'h4, 3'h0};
  // Pull-ups: a line is low while any party pulls it
  wire logic sda_line = !(sda_oe || sda_pull);
  wire logic scl_line = !(scl_oe || scl_pull);
  i2c_master_start_collision dut (.clk_sys(clk_sys), .reset_n(reset_n), .start_request(start_request),
    .baud_reload_value(reload), .collision_clear(collision_clear), .start_busy(start_busy),
    .start_done(start_done), .bus_collision_flag(bus_collision_flag), .sda_in(sda_line),
    .sda_out(sda_out), .sda_oe(sda_oe), .scl_in(scl_line), .scl_out(scl_out), .scl_oe(scl_oe));
  i2c_far_end far (.clk_sys(clk_sys), .go(go), .mode(mode), .sda_oe(sda_oe), .sda_pull(sda_pull),
    .scl_pull(scl_pull));
  // Mode 1 pulls SDA before the check and mode 2 pulls SCL in the first phase, so only they collide
  function automatic logic coll_exp(input logic [2:0] m);
    return m == 3'h1 || m == 3'h2;
  endfunction
  // Two full countdowns bound a clean START from below
  function automatic int min_len(input logic [6:0] r);
    return 2 * r;
  endfunction
  task automatic test_done();
    $display("checks %0d errors %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // One START against the far end in mode m, then a flag clear
  task automatic run(input logic [2:0] m);
    int n;
    logic seen;
    n = 0;
    seen = 1'b0;
    @(posedge clk_sys);
    mode <= m;
    go <= 1'b1;
    reload <= 7'($urandom_range(8, 20));
    @(posedge clk_sys);
    go <= 1'b0;
    repeat (2) @(posedge clk_sys);
    start_request <= 1'b1;
    @(posedge clk_sys);
    start_request <= 1'b0;
    do
    begin
      @(posedge clk_sys);
      #1;
      seen = seen | (start_done === 1'b1);
      n++;
    end while (start_busy === 1'b1 && n < 400);
    `CHK(bus_collision_flag, coll_exp(m))
    `CHK(seen, !coll_exp(m))
    `CHK(scl_oe, !coll_exp(m))
    `CHK(sda_oe, !coll_exp(m))
    `CHK(start_busy, 1'b0)
    `CHK(sda_out | scl_out, 1'b0)
    if (m == 3'h0)
      `CHK(n >= min_len(reload), 1'b1)
    @(posedge clk_sys);
    mode <= 3'h0;
    collision_clear <= 1'b1;
    @(posedge clk_sys);
    collision_clear <= 1'b0;
    repeat (2) @(posedge clk_sys);
    #1 `CHK(bus_collision_flag, 1'b0)
    `CHK(scl_oe, !coll_exp(m))
  endtask
  // 200 MHz system clock
  initial
  begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  // Main sequence
  initial
  begin
    reset_n = 1'b0;
    start_request = 1'b0;
    collision_clear = 1'b0;
    go = 1'b0;
    mode = 3'h0;
    reload = 7'h08;
    err_count = 0;
    tests_run = 0;
    void'($urandom(89931));
    repeat (8) @(posedge clk_sys);
    reset_n <= 1'b1;
    foreach (modes[i])
    begin
      run(modes[i]);
      $display("test %0d mode %0d done", i, modes[i]);
    end
    test_done();
  end
  // Watchdog: six starts need far fewer than 5000 cycles
  initial
  begin
    #25000;
    err_count++;
    test_done();
  end
endmodule // tb_top
`default_nettype wire
